//--- include/tdd_pkg.sv
// Package with register map, field layout, reset values and widths of the tilt detector
package tdd_pkg;

  // Register byte addresses on the serial register port
  localparam logic [7:0] TDD_ADDR_CONFIG       = 8'h3B;
  localparam logic [7:0] TDD_ADDR_SOURCE       = 8'h39;
  localparam logic [7:0] TDD_ADDR_ACK          = 8'h3A;
  localparam logic [7:0] TDD_ADDR_INNER_LOW    = 8'h3C;
  localparam logic [7:0] TDD_ADDR_INNER_HIGH   = 8'h3D;
  localparam logic [7:0] TDD_ADDR_OUTER_LOW    = 8'h3E;
  localparam logic [7:0] TDD_ADDR_OUTER_HIGH   = 8'h3F;

  // Widths
  localparam int unsigned TDD_REG_W      = 8;
  localparam int unsigned TDD_THRESH_W   = 16;
  localparam int unsigned TDD_SAMPLE_W   = 16;
  localparam int unsigned TDD_AXES       = 3;
  localparam int unsigned TDD_FLAGS_W    = 2 * TDD_AXES;

  // Source register fields: bit 7 unused, bit 6 interrupt active, bits 5..0 flags
  localparam int unsigned TDD_SRC_IA_BIT = 6;
  localparam int unsigned TDD_SRC_FLAG_LSB = 0;

  // Configuration register fields
  localparam int unsigned TDD_CFG_IRQ_EN_BIT = 7;
  localparam int unsigned TDD_CFG_LATCH_BIT  = 6;
  localparam int unsigned TDD_CFG_EN_LSB     = 0;

  // Flag layout inside a six-bit direction vector: axis a owns bits 2a+1 (high), 2a (low)
  localparam int unsigned TDD_HIGH_OFS = 1;
  localparam int unsigned TDD_LOW_OFS  = 0;

  // Reset values
  localparam logic [7:0]  TDD_CONFIG_RST = 8'h00;
  localparam logic [15:0] TDD_THRESH_RST = 16'h0000;
  localparam logic [5:0]  TDD_FLAGS_RST  = 6'h00;
  localparam logic [7:0]  TDD_RDATA_RST  = 8'h00;
  localparam logic [7:0]  TDD_RDATA_NONE = 8'h00;

  // Threshold code that stands for full scale
  localparam logic [15:0] TDD_FULL_SCALE_CODE = 16'h7FFF;

endpackage

//--- rtl/tdd_threshold_sel.sv
// Effective clear threshold: inner threshold, or outer one when hysteresis is null
module tdd_threshold_sel
  import tdd_pkg::*;
(
  input  wire logic [TDD_THRESH_W-1:0] i_inner,
  input  wire logic [TDD_THRESH_W-1:0] i_outer,
  output logic      [TDD_THRESH_W-1:0] o_clear,
  output logic                         o_no_hysteresis
);

  always_comb begin
    o_no_hysteresis = (i_inner > i_outer);
    o_clear         = o_no_hysteresis ? i_outer : i_inner;
  end

endmodule

//--- rtl/tdd_axis_cmp.sv
// One axis: magnitude of a signed sample against outer and clear thresholds
module tdd_axis_cmp
  import tdd_pkg::*;
#(
  parameter int unsigned SAMPLE_W = TDD_SAMPLE_W
) (
  input  wire logic [SAMPLE_W-1:0]     i_sample,
  input  wire logic [TDD_THRESH_W-1:0] i_outer,
  input  wire logic [TDD_THRESH_W-1:0] i_clear,
  input  wire logic                    i_high_q,
  input  wire logic                    i_low_q,
  output logic                         o_high_d,
  output logic                         o_low_d
);

  logic [SAMPLE_W:0] ext;
  logic [SAMPLE_W:0] mag;
  logic              neg;

  always_comb begin
    neg = i_sample[SAMPLE_W-1];
    ext = {neg, i_sample};
    // One extra bit so the most negative code has a true magnitude
    mag = neg ? (SAMPLE_W+1)'(-ext) : ext;
    if (mag > (SAMPLE_W+1)'(i_outer)) begin
      o_high_d = !neg;
      o_low_d  = neg;
    end else if (mag < (SAMPLE_W+1)'(i_clear)) begin
      o_high_d = 1'b0;
      o_low_d  = 1'b0;
    end else begin
      // Inside the hysteresis band the last direction stands
      o_high_d = i_high_q;
      o_low_d  = i_low_q;
    end
  end

endmodule

//--- rtl/tdd_tilt_detector.sv
// Tilt direction detector: thresholds, per-axis flags, source latch and acknowledge
module tdd_tilt_detector
  import tdd_pkg::*;
#(
  parameter int unsigned SAMPLE_W = TDD_SAMPLE_W
) (
  input  wire logic                 i_clock,
  input  wire logic                 i_resetn,
  input  wire logic                 i_sample_valid,
  input  wire logic [SAMPLE_W-1:0]  i_x_sample,
  input  wire logic [SAMPLE_W-1:0]  i_y_sample,
  input  wire logic [SAMPLE_W-1:0]  i_z_sample,
  input  wire logic [TDD_REG_W-1:0] i_reg_addr,
  input  wire logic                 i_reg_write,
  input  wire logic [TDD_REG_W-1:0] i_reg_wdata,
  input  wire logic                 i_reg_read,
  output logic      [TDD_REG_W-1:0] o_reg_rdata,
  output logic                      o_reg_rvalid,
  output logic                      o_tilt_irq
);

  // Address match, used by both the write and the read decoders
  function automatic logic tdd_hit(input logic [7:0] addr, input logic [7:0] target);
    tdd_hit = (addr == target);
  endfunction

  // Configuration and threshold storage
  logic [TDD_REG_W-1:0]    tilt_config_reg_q;
  logic [TDD_REG_W-1:0]    inner_threshold_low_q;
  logic [TDD_REG_W-1:0]    inner_threshold_high_q;
  logic [TDD_REG_W-1:0]    outer_threshold_low_q;
  logic [TDD_REG_W-1:0]    outer_threshold_high_q;

  // Derived configuration
  logic                    change_irq_enable;
  logic                    latch_request_bit;
  logic [TDD_FLAGS_W-1:0]  direction_enable;
  logic [TDD_THRESH_W-1:0] inner_threshold_field;
  logic [TDD_THRESH_W-1:0] outer_threshold_field;
  logic [TDD_THRESH_W-1:0] clear_threshold;

  // Direction state
  logic [TDD_FLAGS_W-1:0]  live_q;
  logic [TDD_FLAGS_W-1:0]  live_d;
  logic [TDD_FLAGS_W-1:0]  tilt_d;
  logic [TDD_FLAGS_W-1:0]  tilt_now;
  logic [TDD_FLAGS_W-1:0]  tilt_current;
  logic [TDD_FLAGS_W-1:0]  prev_q;
  logic [TDD_FLAGS_W-1:0]  source_flags_q;
  logic                    tilt_irq_active_q;
  logic                    tilt_irq_active_d;
  logic                    held_q;

  // Acknowledge and change strobes, read mux value
  logic                    ack_read;
  logic                    tilt_change;
  logic [TDD_REG_W-1:0]    read_value;

  logic [TDD_AXES-1:0][SAMPLE_W-1:0] axis_sample;

  assign axis_sample = {i_z_sample, i_y_sample, i_x_sample};

  // Configuration fields
  always_comb begin
    change_irq_enable     = tilt_config_reg_q[TDD_CFG_IRQ_EN_BIT];
    latch_request_bit     = tilt_config_reg_q[TDD_CFG_LATCH_BIT];
    direction_enable      = tilt_config_reg_q[TDD_CFG_EN_LSB +: TDD_FLAGS_W];
    inner_threshold_field = {inner_threshold_high_q, inner_threshold_low_q};
    outer_threshold_field = {outer_threshold_high_q, outer_threshold_low_q};
  end

  // Thresholds are compared as raw codes; the full-scale code needs no scaling here
  // because samples and thresholds share the same full-scale selection

  // Configuration register write; all enables come out of reset cleared
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      tilt_config_reg_q <= TDD_CONFIG_RST;
    end else if (i_reg_write && tdd_hit(i_reg_addr, TDD_ADDR_CONFIG)) begin
      tilt_config_reg_q <= i_reg_wdata;
    end
  end

  // Inner threshold bytes
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      inner_threshold_low_q  <= TDD_THRESH_RST[7:0];
      inner_threshold_high_q <= TDD_THRESH_RST[15:8];
    end else if (i_reg_write) begin
      if (tdd_hit(i_reg_addr, TDD_ADDR_INNER_LOW)) begin
        inner_threshold_low_q <= i_reg_wdata;
      end
      if (tdd_hit(i_reg_addr, TDD_ADDR_INNER_HIGH)) begin
        inner_threshold_high_q <= i_reg_wdata;
      end
    end
  end

  // Outer threshold bytes
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      outer_threshold_low_q  <= TDD_THRESH_RST[7:0];
      outer_threshold_high_q <= TDD_THRESH_RST[15:8];
    end else if (i_reg_write) begin
      if (tdd_hit(i_reg_addr, TDD_ADDR_OUTER_LOW)) begin
        outer_threshold_low_q <= i_reg_wdata;
      end
      if (tdd_hit(i_reg_addr, TDD_ADDR_OUTER_HIGH)) begin
        outer_threshold_high_q <= i_reg_wdata;
      end
    end
  end

  // A misprogrammed pair (inner above outer) falls back to the outer threshold alone
  tdd_threshold_sel u_threshold_sel (
    .i_inner         (inner_threshold_field),
    .i_outer         (outer_threshold_field),
    .o_clear         (clear_threshold),
    .o_no_hysteresis ()
  );

  // Per-axis comparators, fed with the state each axis currently holds
  for (genvar a = 0; a < TDD_AXES; a++) begin : g_axis
    tdd_axis_cmp #(
      .SAMPLE_W (SAMPLE_W)
    ) u_axis_cmp (
      .i_sample (axis_sample[a]),
      .i_outer  (outer_threshold_field),
      .i_clear  (clear_threshold),
      .i_high_q (live_q[2*a+TDD_HIGH_OFS]),
      .i_low_q  (live_q[2*a+TDD_LOW_OFS]),
      .o_high_d (live_d[2*a+TDD_HIGH_OFS]),
      .o_low_d  (live_d[2*a+TDD_LOW_OFS])
    );
  end

  // Raw direction state advances once per produced sample
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      live_q <= TDD_FLAGS_RST;
    end else if (i_sample_valid) begin
      live_q <= live_d;
    end
  end

  // Disabled directions are invisible to the change detector and the source flags
  always_comb begin
    tilt_d       = live_d & direction_enable;
    tilt_now     = live_q & direction_enable;
    tilt_current = i_sample_valid ? tilt_d : tilt_now;
  end

  // Previously recorded tilt, as seen at the last sample
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      prev_q <= TDD_FLAGS_RST;
    end else if (i_sample_valid) begin
      prev_q <= tilt_d;
    end
  end

  assign tilt_change = i_sample_valid && (tilt_d != prev_q);
  assign ack_read    = i_reg_read && tdd_hit(i_reg_addr, TDD_ADDR_ACK);

  // Interrupt-active flag; a change in the acknowledge cycle keeps it set
  always_comb begin
    tilt_irq_active_d = tilt_irq_active_q;
    if (tilt_change) begin
      tilt_irq_active_d = 1'b1;
    end else if (ack_read) begin
      tilt_irq_active_d = 1'b0;
    end
  end

  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      tilt_irq_active_q <= 1'b0;
    end else begin
      tilt_irq_active_q <= tilt_irq_active_d;
    end
  end

  // Source flags: follow the tilt when not latching, else hold the first change
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      source_flags_q <= TDD_FLAGS_RST;
      held_q         <= 1'b0;
    end else if (!latch_request_bit) begin
      source_flags_q <= tilt_current;
      held_q         <= 1'b0;
    end else if (ack_read) begin
      // Refresh with the present tilt; a change in this cycle re-arms the hold
      source_flags_q <= tilt_current;
      held_q         <= tilt_change;
    end else if (tilt_change && !held_q) begin
      source_flags_q <= tilt_d;
      held_q         <= 1'b1;
    end
  end

  // Interrupt output mirrors the next flag value so it stays aligned with the register
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      o_tilt_irq <= 1'b0;
    end else begin
      o_tilt_irq <= tilt_irq_active_d & change_irq_enable;
    end
  end

  // Read multiplexer; the acknowledge location and unmapped addresses read zero
  always_comb begin
    read_value = TDD_RDATA_NONE;
    if (tdd_hit(i_reg_addr, TDD_ADDR_SOURCE)) begin
      read_value                                      = TDD_RDATA_NONE;
      read_value[TDD_SRC_IA_BIT]                      = tilt_irq_active_q;
      read_value[TDD_SRC_FLAG_LSB +: TDD_FLAGS_W]     = source_flags_q;
    end else if (tdd_hit(i_reg_addr, TDD_ADDR_CONFIG)) begin
      read_value = tilt_config_reg_q;
    end else if (tdd_hit(i_reg_addr, TDD_ADDR_INNER_LOW)) begin
      read_value = inner_threshold_low_q;
    end else if (tdd_hit(i_reg_addr, TDD_ADDR_INNER_HIGH)) begin
      read_value = inner_threshold_high_q;
    end else if (tdd_hit(i_reg_addr, TDD_ADDR_OUTER_LOW)) begin
      read_value = outer_threshold_low_q;
    end else if (tdd_hit(i_reg_addr, TDD_ADDR_OUTER_HIGH)) begin
      read_value = outer_threshold_high_q;
    end
  end

  // Read data returns one cycle after the strobe and reflects pre-acknowledge state
  always_ff @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      o_reg_rdata  <= TDD_RDATA_RST;
      o_reg_rvalid <= 1'b0;
    end else begin
      o_reg_rvalid <= i_reg_read;
      o_reg_rdata  <= i_reg_read ? read_value : TDD_RDATA_NONE;
    end
  end

endmodule

//--- sim/tdd_tilt_sva.sv
// Port-level assertion checker for the tilt direction detector
module tdd_tilt_sva (
  input wire logic       i_clock,
  input wire logic       i_resetn,
  input wire logic       i_sample_valid,
  input wire logic [7:0] i_reg_addr,
  input wire logic       i_reg_write,
  input wire logic       i_reg_read,
  input wire logic [7:0] o_reg_rdata,
  input wire logic       o_reg_rvalid,
  input wire logic       o_tilt_irq
);
  default clocking @(posedge i_clock); endclocking
  default disable iff (!i_resetn);
  logic ack;
  logic cfg_wr;
  assign ack    = i_reg_read && i_reg_addr == 8'h3A;
  assign cfg_wr = i_reg_write && i_reg_addr == 8'h3B;
  property p_rvalid; i_reg_read |=> o_reg_rvalid; endproperty
  a_rvalid: assert property (p_rvalid) else $error("read not answered");
  property p_rv_cause; o_reg_rvalid |-> $past(i_reg_read); endproperty
  a_rv_cause: assert property (p_rv_cause) else $error("stray read valid");
  property p_idle; !o_reg_rvalid |-> o_reg_rdata == 8'h00; endproperty
  a_idle: assert property (p_idle) else $error("read data not zero when idle");
  property p_bit7; i_reg_read && i_reg_addr == 8'h39 |=> !o_reg_rdata[7]; endproperty
  a_bit7: assert property (p_bit7) else $error("unused source bit set");
  property p_ack_data; ack |=> o_reg_rdata == 8'h00; endproperty
  a_ack_data: assert property (p_ack_data) else $error("ack read not zero");
  property p_ack_clr; ack && !i_sample_valid |=> !o_tilt_irq; endproperty
  a_ack_clr: assert property (p_ack_clr) else $error("ack left irq set");
  // A config write reaches the output two edges later: register, then output flop
  property p_irq_rise; $rose(o_tilt_irq) |-> $past(i_sample_valid) || $past(cfg_wr, 2); endproperty
  a_irq_rise: assert property (p_irq_rise) else $error("irq rose without cause");
  property p_irq_hold; o_tilt_irq && !ack && !$past(cfg_wr) |=> o_tilt_irq; endproperty
  a_irq_hold: assert property (p_irq_hold) else $error("irq dropped without ack");
  property p_rst; $rose(i_resetn) |-> !o_tilt_irq && !o_reg_rvalid; endproperty
  a_rst: assert property (p_rst) else $error("outputs active after reset");
endmodule

//--- sim/tdd_host_model.sv
// Host model driving the tilt detector's register port
module tdd_host_model (
  input  wire logic       i_clock,
  input  wire logic [7:0] i_rdata,
  input  wire logic       i_rvalid,
  output logic      [7:0] o_addr,
  output logic            o_write,
  output logic      [7:0] o_wdata,
  output logic            o_read
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    o_addr  = 8'h00;
    o_write = 1'b0;
    o_wdata = 8'h00;
    o_read  = 1'b0;
  end
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clock) #1;
    o_addr  = a;
    o_wdata = d;
    o_write = 1'b1;
    @(posedge i_clock) #1;
    o_write = 1'b0;
    o_addr  = ~a;
    o_wdata = ~d;
  endtask
  // Ack reads go through here too, so latched status is released by the host
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge i_clock) #1;
    o_addr = a;
    o_read = 1'b1;
    @(posedge i_clock) #1;
    o_read = 1'b0;
    d      = i_rvalid ? i_rdata : 8'hXX;
    o_addr = ~a;
  endtask
endmodule

//--- sim/tb_top.sv
// Self-checking testbench for the tilt direction detector
module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic        clock, resetn, s_valid, wr_s, rd_s, rvalid, irq;
  logic [15:0] x_s, y_s, z_s;
  logic [7:0]  addr, wdata, rdata;
  int          error_cnt, checks, cyc;
  tdd_tilt_detector DUT (.i_clock(clock), .i_resetn(resetn), .i_sample_valid(s_valid),
    .i_x_sample(x_s), .i_y_sample(y_s), .i_z_sample(z_s), .i_reg_addr(addr),
    .i_reg_write(wr_s), .i_reg_wdata(wdata), .i_reg_read(rd_s), .o_reg_rdata(rdata),
    .o_reg_rvalid(rvalid), .o_tilt_irq(irq));
  tdd_host_model host (.i_clock(clock), .i_rdata(rdata), .i_rvalid(rvalid), .o_addr(addr),
    .o_write(wr_s), .o_wdata(wdata), .o_read(rd_s));
  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end
  task automatic end_sim();
    $display("Checks %0d errors %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      error_cnt++;
      $display("Error timeout expected finish before %0d cycles seen %0d", 5000, cyc);
      end_sim();
    end
  end
  task automatic chk(string n, logic [7:0] e, logic [7:0] g);
    checks++;
    if (g !== e) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic rdchk(logic [7:0] a, logic [7:0] e);
    logic [7:0] d;
    host.rd(a, d);
    chk($sformatf("reg %h", a), e, d);
  endtask
  task automatic smp(logic [15:0] x, logic [15:0] y, logic [15:0] z, logic e);
    @(posedge clock) #1;
    s_valid = 1'b1;
    x_s = x;
    y_s = y;
    z_s = z;
    @(posedge clock) #1;
    s_valid = 1'b0;
    x_s = ~x;
    chk("irq", {7'h00, e}, {7'h00, irq});
  endtask
  task automatic ack();
    rdchk(8'h3A, 8'h00);
    chk("irq", 8'h00, {7'h00, irq});
  endtask
  // Inner kept at or below outer except where a scenario means otherwise
  task automatic thr(logic [15:0] inner, logic [15:0] outer);
    host.wr(8'h3C, inner[7:0]);
    host.wr(8'h3D, inner[15:8]);
    host.wr(8'h3E, outer[7:0]);
    host.wr(8'h3F, outer[15:8]);
  endtask
  task automatic t_regs();
    logic [7:0] ra[7] = '{8'h39, 8'h3B, 8'h3C, 8'h3D, 8'h3E, 8'h3F, 8'h50};
    foreach (ra[i]) rdchk(ra[i], 8'h00);
    host.wr(8'h39, 8'hFF);
    rdchk(8'h39, 8'h00);
    for (int i = 0; i < 4; i++) host.wr(8'(8'h3C + i), 8'(8'hA5 ^ i));
    for (int i = 0; i < 4; i++) rdchk(8'(8'h3C + i), 8'(8'hA5 ^ i));
  endtask
  task automatic t_hyst();
    thr(16'h1000, 16'h2000);
    host.wr(8'h3B, 8'hBF);
    smp(16'h3000, 16'h0000, 16'h0000, 1'b1);
    rdchk(8'h39, 8'h42);
    ack();
    smp(16'h1800, 16'h0000, 16'h0000, 1'b0);
    rdchk(8'h39, 8'h02);
    smp(16'h0800, 16'h0000, 16'h0000, 1'b1);
    rdchk(8'h39, 8'h40);
    ack();
    smp(16'hD000, 16'h3000, 16'hD000, 1'b1);
    rdchk(8'h39, 8'h59);
    ack();
    smp(16'h0000, 16'h0000, 16'h0000, 1'b1);
    ack();
  endtask
  task automatic t_mask();
    host.wr(8'h3B, 8'h81);
    smp(16'h3000, 16'h3000, 16'h3000, 1'b0);
    rdchk(8'h39, 8'h00);
    smp(16'hD000, 16'hD000, 16'hD000, 1'b1);
    rdchk(8'h39, 8'h41);
    ack();
    smp(16'h0000, 16'h0000, 16'h0000, 1'b1);
    ack();
  endtask
  task automatic t_nohyst();
    thr(16'h3000, 16'h2000);
    host.wr(8'h3B, 8'h02);
    smp(16'h2800, 16'h0000, 16'h0000, 1'b0);
    rdchk(8'h39, 8'h42);
    host.wr(8'h3B, 8'h82);
    // The new enable is in the register now; the output flop picks it up one edge later
    @(posedge clock) #1;
    chk("irq", 8'h01, {7'h00, irq});
    ack();
    smp(16'h1F00, 16'h0000, 16'h0000, 1'b1);
    rdchk(8'h39, 8'h40);
    ack();
  endtask
  task automatic t_latch();
    thr(16'h7FFF, 16'h7FFF);
    host.wr(8'h3B, 8'hC3);
    smp(16'h7FFF, 16'h0000, 16'h0000, 1'b0);
    smp(16'h8000, 16'h0000, 16'h0000, 1'b1);
    smp(16'h0000, 16'h0000, 16'h0000, 1'b1);
    rdchk(8'h39, 8'h41);
    ack();
    rdchk(8'h39, 8'h00);
  endtask
  initial begin
    {resetn, s_valid, x_s, y_s, z_s} = '0;
    {error_cnt, checks, cyc} = '0;
    repeat (20) @(posedge clock);
    #1 resetn = 1'b1;
    t_regs();
    t_hyst();
    t_mask();
    t_nohyst();
    t_latch();
    end_sim();
  end
endmodule
bind tdd_tilt_detector tdd_tilt_sva u_sva (.i_clock, .i_resetn, .i_sample_valid, .i_reg_addr,
  .i_reg_write, .i_reg_read, .o_reg_rdata, .o_reg_rvalid, .o_tilt_irq);
